// ### sfb_params.svh
// Purpose: constants of the status flag bit-operation block
// Assumes: 32-bit AHB-Lite data, word registers
// Notes:   flag positions and offsets are fixed here and nowhere else
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

`define SFB_ADDR_FLAGS     32'h0000_0000
`define SFB_ADDR_CMD       32'h0000_0004
`define SFB_ADDR_GPR_BASE  32'h0000_0020
`define SFB_ADDR_GPR_LAST  32'h0000_003c
`define SFB_WORD_ALIGN     2'h0
`define SFB_GPR_IDX_HI     4
`define SFB_GPR_IDX_LO     2
`define SFB_NUM_GPR        8
`define SFB_CMD_W          11

`define SFB_FLAG_C         3'h0
`define SFB_FLAG_Z         3'h1
`define SFB_FLAG_N         3'h2
`define SFB_FLAG_V         3'h3
`define SFB_FLAG_S         3'h4
`define SFB_FLAG_H         3'h5
`define SFB_FLAG_T         3'h6
`define SFB_FLAG_I         3'h7

`define SFB_FLAGS_RST      8'h00
`define SFB_GPR_RST        8'h00
`define SFB_CMD_RST        11'h000
`define SFB_RDATA_RST      32'h0000_0000

`endif

// ### sfb_pkg.sv
// Purpose: types of the status flag bit-operation block
// Assumes: sfb_params.svh holds every number
// Notes:   operation codes follow declaration order
package sfb_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_GEN_RAISE,
    OP_GEN_LOWER,
    OP_REGBIT_TO_TBIT,
    OP_TBIT_TO_REGBIT,
    OP_CARRY_SET,
    OP_CARRY_CLEAR,
    OP_NEG_SET,
    OP_NEG_CLEAR,
    OP_ZERO_SET,
    OP_ZERO_CLEAR,
    OP_IRQ_ENABLE,
    OP_IRQ_DISABLE,
    OP_SIGN_SET,
    OP_SIGN_CLEAR,
    OP_OVF_SET,
    OP_OVF_CLEAR,
    OP_TBIT_RAISE,
    OP_TBIT_LOWER,
    OP_HC_RAISE,
    OP_HC_LOWER
  } sfb_op_type;

  typedef struct packed {
    logic [2:0] reg_idx;
    logic [2:0] bit_idx;
    sfb_op_type op;
  } sfb_cmd_type;

  typedef struct packed {
    logic       wr_en;
    logic [2:0] idx;
    logic       val;
  } sfb_flag_req_type;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_CMD,
    SEL_GPR
  } sfb_sel_type;

endpackage : sfb_pkg

// ### sfb_flag_unit.sv
// Purpose: shared flag write datapath for every flag operation
// Assumes: caller qualifies exec with a command write
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "sfb_params.svh"

module sfb_flag_unit
  import sfb_pkg::*;
(
  // command
  input  wire logic        exec,
  input  wire sfb_cmd_type cmd,
  input  wire logic        src_bit,
  // flags
  input  wire logic [7:0]  flags_in,
  output logic [7:0]       flags_out
);

  // dedicated ops are only aliases of the generic raise/lower path
  function automatic sfb_flag_req_type to_req(input sfb_cmd_type c, input logic sb);
    sfb_flag_req_type r;
    r = '{wr_en: 1'b1, idx: c.bit_idx, val: 1'b0};
    case (c.op)
      OP_GEN_RAISE:      r.val = 1'b1;                                 // RULE_10
      OP_GEN_LOWER:      r.val = 1'b0;                                 // RULE_10
      OP_REGBIT_TO_TBIT: r = '{wr_en: 1'b1, idx: `SFB_FLAG_T, val: sb}; // RULE_11
      OP_CARRY_SET:      r = '{wr_en: 1'b1, idx: `SFB_FLAG_C, val: 1'b1}; // RULE_02
      OP_CARRY_CLEAR:    r = '{wr_en: 1'b1, idx: `SFB_FLAG_C, val: 1'b0}; // RULE_02
      OP_NEG_SET:        r = '{wr_en: 1'b1, idx: `SFB_FLAG_N, val: 1'b1}; // RULE_03
      OP_NEG_CLEAR:      r = '{wr_en: 1'b1, idx: `SFB_FLAG_N, val: 1'b0}; // RULE_03
      OP_ZERO_SET:       r = '{wr_en: 1'b1, idx: `SFB_FLAG_Z, val: 1'b1}; // RULE_04
      OP_ZERO_CLEAR:     r = '{wr_en: 1'b1, idx: `SFB_FLAG_Z, val: 1'b0}; // RULE_04
      OP_IRQ_ENABLE:     r = '{wr_en: 1'b1, idx: `SFB_FLAG_I, val: 1'b1}; // RULE_05
      OP_IRQ_DISABLE:    r = '{wr_en: 1'b1, idx: `SFB_FLAG_I, val: 1'b0}; // RULE_05
      OP_SIGN_SET:       r = '{wr_en: 1'b1, idx: `SFB_FLAG_S, val: 1'b1}; // RULE_06
      OP_SIGN_CLEAR:     r = '{wr_en: 1'b1, idx: `SFB_FLAG_S, val: 1'b0}; // RULE_06
      OP_OVF_SET:        r = '{wr_en: 1'b1, idx: `SFB_FLAG_V, val: 1'b1}; // RULE_07
      OP_OVF_CLEAR:      r = '{wr_en: 1'b1, idx: `SFB_FLAG_V, val: 1'b0}; // RULE_07
      OP_TBIT_RAISE:     r = '{wr_en: 1'b1, idx: `SFB_FLAG_T, val: 1'b1}; // RULE_08
      OP_TBIT_LOWER:     r = '{wr_en: 1'b1, idx: `SFB_FLAG_T, val: 1'b0}; // RULE_08
      OP_HC_RAISE:       r = '{wr_en: 1'b1, idx: `SFB_FLAG_H, val: 1'b1}; // RULE_09
      OP_HC_LOWER:       r = '{wr_en: 1'b1, idx: `SFB_FLAG_H, val: 1'b0}; // RULE_09
      default:           r.wr_en = 1'b0;
    endcase
    return r;
  endfunction : to_req

  sfb_flag_req_type req;

  always_comb begin
    req       = to_req(cmd, src_bit);
    flags_out = flags_in;
    if (exec && req.wr_en) begin
      flags_out[req.idx] = req.val; // RULE_12
    end
  end

endmodule : sfb_flag_unit

// ### sfb_top.sv
// Purpose: status flag bit operations behind an AHB-Lite register slave
// Assumes: single slave, word transfers only, response always OKAY
// Notes:   a command executes in the data phase of its write
// Notes on behaviour
// RULE_01: tbit_to_reg_bit_op copies transfer flag into chosen dest_reg bit, flags unchanged, one cycle.
// RULE_02: carry_set_op sets carry, carry_clear_op clears it; nothing else, one cycle.
// RULE_03: negative_set_op sets negative flag, negative_clear_op clears it; one cycle.
// RULE_04: zero_set_op sets zero flag, zero_clear_op clears it; one cycle.
// RULE_05: irq_enable_op sets global interrupt enable, irq_disable_op clears it; one cycle.
// RULE_06: sign_set_op sets signed test flag, sign_clear_op clears it; one cycle.
// RULE_07: overflow_set_op sets overflow flag, overflow_clear_op clears it; one cycle.
// RULE_08: tbit_raise_op sets transfer flag, tbit_lower_op clears it; one cycle.
// RULE_09: half_carry_raise_op sets half carry, half_carry_lower_op clears it; one cycle.
// RULE_10: generic raise/lower writes 1/0 to the flag picked by the index; one cycle.
// RULE_11: reg_bit_to_tbit_op copies chosen source_reg bit into transfer flag; one cycle.
// RULE_12: opcodes and flag positions are chosen here; dedicated ops reuse generic path.
`timescale 1ns/1ps
`include "sfb_params.svh"

module sfb_top
  import sfb_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core state
  output logic [7:0]       status_flags,
  output logic             irq_enable
);

  function automatic sfb_sel_type decode(input logic [31:0] a);
    if (a == `SFB_ADDR_FLAGS) begin
      return SEL_FLAGS;
    end else if (a == `SFB_ADDR_CMD) begin
      return SEL_CMD;
    end else if (a >= `SFB_ADDR_GPR_BASE && a <= `SFB_ADDR_GPR_LAST && a[1:0] == `SFB_WORD_ALIGN) begin
      return SEL_GPR;
    end
    return SEL_NONE;
  endfunction : decode

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction : bit_mask

  // state
  logic [7:0]      flags_q, flags_d;
  logic [7:0]      gpr_q [`SFB_NUM_GPR];
  logic [7:0]      gpr_d [`SFB_NUM_GPR];
  sfb_cmd_type     last_cmd_q, last_cmd_d;
  logic            dph_wr_q, dph_wr_d;
  sfb_sel_type     sel_q, sel_d;
  logic [2:0]      gidx_q, gidx_d;
  logic [31:0]     hrdata_q, hrdata_d;
  logic            irq_en_q;
  logic            hreadyout_q;
  logic            hresp_q;

  // decode
  logic            aph_valid;
  sfb_sel_type     aph_sel;
  logic [2:0]      aph_gidx;
  logic            exec_go;
  sfb_cmd_type     cmd_w;
  logic            src_bit;
  logic [7:0]      flags_unit;

  assign aph_valid = hsel && htrans[1] && hready;
  assign aph_sel   = decode(haddr);
  assign aph_gidx  = haddr[`SFB_GPR_IDX_HI:`SFB_GPR_IDX_LO];
  assign exec_go   = dph_wr_q && (sel_q == SEL_CMD);
  assign cmd_w     = sfb_cmd_type'(hwdata[`SFB_CMD_W-1:0]);
  assign src_bit   = gpr_q[cmd_w.reg_idx][cmd_w.bit_idx];

  sfb_flag_unit i_sfb_flag_unit (
    .exec      (exec_go),
    .cmd       (cmd_w),
    .src_bit   (src_bit),
    .flags_in  (flags_q),
    .flags_out (flags_unit)
  );

  always_comb begin
    dph_wr_d   = aph_valid && hwrite;
    sel_d      = aph_valid ? aph_sel : SEL_NONE;
    gidx_d     = aph_gidx;
    last_cmd_d = exec_go ? cmd_w : last_cmd_q;
    flags_d    = flags_unit; // RULE_12
    gpr_d      = gpr_q;
    if (dph_wr_q && sel_q == SEL_FLAGS) begin
      flags_d = hwdata[7:0];
    end
    if (dph_wr_q && sel_q == SEL_GPR) begin
      gpr_d[gidx_q] = hwdata[7:0];
    end
    if (exec_go && cmd_w.op == OP_TBIT_TO_REGBIT) begin
      gpr_d[cmd_w.reg_idx][cmd_w.bit_idx] = flags_q[`SFB_FLAG_T]; // RULE_01
    end
    // reads see the next values so a write right before a read is not stale
    hrdata_d = `SFB_RDATA_RST;
    if (aph_valid && !hwrite) begin
      case (aph_sel)
        SEL_FLAGS: hrdata_d = {24'h00_0000, flags_d};
        SEL_CMD:   hrdata_d = {21'h00_0000, last_cmd_d};
        SEL_GPR:   hrdata_d = {24'h00_0000, gpr_d[aph_gidx]};
        default:   hrdata_d = `SFB_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q     <= `SFB_FLAGS_RST;
      last_cmd_q  <= `SFB_CMD_RST;
      dph_wr_q    <= 1'b0;
      sel_q       <= SEL_NONE;
      gidx_q      <= 3'h0;
      hrdata_q    <= `SFB_RDATA_RST;
      irq_en_q    <= 1'b0;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      flags_q     <= flags_d;
      last_cmd_q  <= last_cmd_d;
      dph_wr_q    <= dph_wr_d;
      sel_q       <= sel_d;
      gidx_q      <= gidx_d;
      hrdata_q    <= hrdata_d;
      irq_en_q    <= flags_d[`SFB_FLAG_I]; // RULE_05
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SFB_NUM_GPR; gi++) begin : g_gpr
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gpr_q[gi] <= `SFB_GPR_RST;
        end else begin
          gpr_q[gi] <= gpr_d[gi];
        end
      end
    end
  endgenerate

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  // never an error, but still taken from a flop like every other output
  assign hresp        = hresp_q;
  assign status_flags = flags_q;
  assign irq_enable   = irq_en_q;

  property p_rule01;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && cmd_w.op == OP_TBIT_TO_REGBIT |=>
      gpr_q[last_cmd_q.reg_idx][last_cmd_q.bit_idx] == $past(flags_q[`SFB_FLAG_T]) && flags_q == $past(flags_q);
  endproperty
  a_rule01: assert property (p_rule01) else $error("transfer flag not copied into register bit"); // RULE_01

  property p_rule02;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_CARRY_SET || cmd_w.op == OP_CARRY_CLEAR) |=>
      flags_q[`SFB_FLAG_C] == (last_cmd_q.op == OP_CARRY_SET)
      && (flags_q | bit_mask(`SFB_FLAG_C)) == ($past(flags_q) | bit_mask(`SFB_FLAG_C));
  endproperty
  a_rule02: assert property (p_rule02) else $error("carry op gave wrong flags"); // RULE_02

  property p_rule03;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_NEG_SET || cmd_w.op == OP_NEG_CLEAR) |=>
      flags_q[`SFB_FLAG_N] == (last_cmd_q.op == OP_NEG_SET)
      && (flags_q | bit_mask(`SFB_FLAG_N)) == ($past(flags_q) | bit_mask(`SFB_FLAG_N));
  endproperty
  a_rule03: assert property (p_rule03) else $error("negative flag op gave wrong flags"); // RULE_03

  property p_rule04;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_ZERO_SET || cmd_w.op == OP_ZERO_CLEAR) |=>
      flags_q[`SFB_FLAG_Z] == (last_cmd_q.op == OP_ZERO_SET)
      && (flags_q | bit_mask(`SFB_FLAG_Z)) == ($past(flags_q) | bit_mask(`SFB_FLAG_Z));
  endproperty
  a_rule04: assert property (p_rule04) else $error("zero flag op gave wrong flags"); // RULE_04

  property p_rule05;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_IRQ_ENABLE || cmd_w.op == OP_IRQ_DISABLE) |=>
      irq_enable == (last_cmd_q.op == OP_IRQ_ENABLE) && irq_enable == flags_q[`SFB_FLAG_I]
      && (flags_q | bit_mask(`SFB_FLAG_I)) == ($past(flags_q) | bit_mask(`SFB_FLAG_I));
  endproperty
  a_rule05: assert property (p_rule05) else $error("interrupt enable op failed"); // RULE_05

  property p_rule06;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_SIGN_SET || cmd_w.op == OP_SIGN_CLEAR) |=>
      flags_q[`SFB_FLAG_S] == (last_cmd_q.op == OP_SIGN_SET)
      && (flags_q | bit_mask(`SFB_FLAG_S)) == ($past(flags_q) | bit_mask(`SFB_FLAG_S));
  endproperty
  a_rule06: assert property (p_rule06) else $error("signed test flag op gave wrong flags"); // RULE_06

  property p_rule07;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_OVF_SET || cmd_w.op == OP_OVF_CLEAR) |=>
      flags_q[`SFB_FLAG_V] == (last_cmd_q.op == OP_OVF_SET)
      && (flags_q | bit_mask(`SFB_FLAG_V)) == ($past(flags_q) | bit_mask(`SFB_FLAG_V));
  endproperty
  a_rule07: assert property (p_rule07) else $error("overflow flag op gave wrong flags"); // RULE_07

  property p_rule08;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_TBIT_RAISE || cmd_w.op == OP_TBIT_LOWER) |=>
      flags_q[`SFB_FLAG_T] == (last_cmd_q.op == OP_TBIT_RAISE)
      && (flags_q | bit_mask(`SFB_FLAG_T)) == ($past(flags_q) | bit_mask(`SFB_FLAG_T));
  endproperty
  a_rule08: assert property (p_rule08) else $error("transfer flag op gave wrong flags"); // RULE_08

  property p_rule09;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_HC_RAISE || cmd_w.op == OP_HC_LOWER) |=>
      flags_q[`SFB_FLAG_H] == (last_cmd_q.op == OP_HC_RAISE)
      && (flags_q | bit_mask(`SFB_FLAG_H)) == ($past(flags_q) | bit_mask(`SFB_FLAG_H));
  endproperty
  a_rule09: assert property (p_rule09) else $error("half carry op gave wrong flags"); // RULE_09

  property p_rule10;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && (cmd_w.op == OP_GEN_RAISE || cmd_w.op == OP_GEN_LOWER) |=>
      flags_q[last_cmd_q.bit_idx] == (last_cmd_q.op == OP_GEN_RAISE)
      && (flags_q | bit_mask(last_cmd_q.bit_idx)) == ($past(flags_q) | bit_mask(last_cmd_q.bit_idx));
  endproperty
  a_rule10: assert property (p_rule10) else $error("generic flag op gave wrong flags"); // RULE_10

  property p_rule11;
    @(posedge hclk) disable iff (!hresetn)
    exec_go && cmd_w.op == OP_REGBIT_TO_TBIT |=> flags_q[`SFB_FLAG_T] == $past(src_bit)
      && (flags_q | bit_mask(`SFB_FLAG_T)) == ($past(flags_q) | bit_mask(`SFB_FLAG_T));
  endproperty
  a_rule11: assert property (p_rule11) else $error("register bit not stored into transfer flag"); // RULE_11

endmodule : sfb_top

// ### sfb_status_flag_bit_ops_test.sv
// Purpose: self-checking bench of the flag bit-operation block over AHB-Lite
// Assumes: single slave, hready fed back from hreadyout, word transfers only
// Notes:   every scenario is one task; flags are checked at the port and by bus read
`timescale 1ns/1ps
`include "sfb_params.svh"

module sfb_status_flag_bit_ops_test
  import sfb_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  status_flags;
  logic        irq_enable;
  int          miscompares;
  int          n_tests;
  logic [2:0]  pos [8];

  sfb_top i_sfb_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .status_flags(status_flags), .irq_enable(irq_enable)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // entered just after a rising edge; returns at the edge ending the data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(name, exp, rd);
  endtask : rdchk

  task automatic exec(input int op, input logic [2:0] bidx, input logic [2:0] ridx);
    sfb_cmd_type c;
    c.op      = sfb_op_type'(op);
    c.bit_idx = bidx;
    c.reg_idx = ridx;
    wr(`SFB_ADDR_CMD, {21'h000000, c});
  endtask : exec

  // the port is looked at right after the executing edge: one cycle, no slack
  task automatic check_flags(input logic [7:0] exp);
    #1;
    chk("status_flags", {24'h0, exp}, {24'h0, status_flags});
    chk("irq_enable", {31'h0, exp[`SFB_FLAG_I]}, {31'h0, irq_enable});
    rdchk("flags_reg", `SFB_ADDR_FLAGS, {24'h0, exp});
  endtask : check_flags

  task automatic t_reset;
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    check_flags(`SFB_FLAGS_RST);
    rdchk("gpr0", `SFB_ADDR_GPR_BASE, {24'h0, `SFB_GPR_RST});
    $display("test reset done");
  endtask : t_reset

  // order of pos[] matches the set/clear op pairs starting at op 5
  task automatic t_dedicated;
    logic [7:0] m;
    for (int k = 0; k < 8; k++) begin
      m = 8'h01 << pos[k];
      wr(`SFB_ADDR_FLAGS, 32'h0);
      exec(5 + 2 * k, 3'h0, 3'h0);
      check_flags(m);
      wr(`SFB_ADDR_FLAGS, 32'hff);
      exec(6 + 2 * k, 3'h0, 3'h0);
      check_flags(~m);
    end
    $display("test dedicated done");
  endtask : t_dedicated

  task automatic t_generic;
    for (int i = 0; i < 8; i++) begin
      wr(`SFB_ADDR_FLAGS, 32'h0);
      exec(1, i[2:0], 3'h7);
      check_flags(8'h01 << i);
      wr(`SFB_ADDR_FLAGS, 32'hff);
      exec(2, i[2:0], 3'h0);
      check_flags(~(8'h01 << i));
    end
    $display("test generic done");
  endtask : t_generic

  task automatic t_reg_to_t;
    logic [7:0] t;
    t = 8'h01 << `SFB_FLAG_T;
    wr(`SFB_ADDR_GPR_BASE + 32'hc, 32'h80);
    wr(`SFB_ADDR_FLAGS, {24'h0, ~t});
    exec(3, 3'h7, 3'h3);
    check_flags(8'hff);
    exec(3, 3'h0, 3'h3);
    check_flags(~t);
    $display("test reg_to_t done");
  endtask : t_reg_to_t

  task automatic t_t_to_reg;
    logic [7:0] t;
    t = 8'h01 << `SFB_FLAG_T;
    wr(`SFB_ADDR_GPR_BASE + 32'h14, 32'hf0);
    wr(`SFB_ADDR_FLAGS, {24'h0, t | 8'h05});
    exec(4, 3'h2, 3'h5);
    rdchk("gpr5", `SFB_ADDR_GPR_BASE + 32'h14, 32'hf4);
    check_flags(t | 8'h05);
    wr(`SFB_ADDR_FLAGS, 32'h05);
    exec(4, 3'h7, 3'h5);
    rdchk("gpr5", `SFB_ADDR_GPR_BASE + 32'h14, 32'h74);
    check_flags(8'h05);
    $display("test t_to_reg done");
  endtask : t_t_to_reg

  // unmapped or misaligned place, nop and unused opcode must leave flags and registers alone (nop and unused opcode still replace the command word);
  // the command word reads back the last one executed (reg 5, bit 7, op 4 from t_t_to_reg)
  task automatic t_refused;
    rdchk("last_cmd", `SFB_ADDR_CMD, 32'h5e4);
    wr(`SFB_ADDR_FLAGS, 32'h5a);
    wr(32'h10, 32'hff);
    wr(`SFB_ADDR_GPR_BASE + 32'h1, 32'hff);
    rdchk("unmapped", 32'h10, 32'h0);
    rdchk("gpr0", `SFB_ADDR_GPR_BASE, 32'h0);
    exec(0, 3'h1, 3'h1);
    check_flags(8'h5a);
    exec(21, 3'h1, 3'h1);
    check_flags(8'h5a);
    $display("test refused done");
  endtask : t_refused

  initial begin
    pos = '{`SFB_FLAG_C, `SFB_FLAG_N, `SFB_FLAG_Z, `SFB_FLAG_I,
            `SFB_FLAG_S, `SFB_FLAG_V, `SFB_FLAG_T, `SFB_FLAG_H};
    miscompares = 0;
    n_tests     = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_dedicated();
    t_generic();
    t_reg_to_t();
    t_t_to_reg();
    t_refused();
    end_sim();
  end

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_sim();
  end

endmodule : sfb_status_flag_bit_ops_test
